// ===== rtl/dbg_pin_mux.sv
/*
  Debug pin function select: muxes serial wire debug, viewer and trace
  signals onto shared port pins, with an AHB-Lite register file.
  Assumes pad inputs are asynchronous; debug core signals are on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dbg_pin_mux
  import dbg_pin_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic [4:0]  pad_in,
  output var  pad_drv_t    pad_drv,
  input  wire logic        dbg_data_out,
  input  wire logic        dbg_data_oe,
  input  wire logic        viewer_trace_output,
  input  wire logic        trace_clock_output,
  input  wire logic        trace_data_output,
  output var  logic        dbg_data_in,
  output var  logic        dbg_clk_in,
  input  wire logic        stop_mode,
  input  wire logic        core_halted,
  input  wire logic        reset_pin_n,
  output var  logic        wdt_stop,
  output var  logic        dbg_enable
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronise pad inputs and reset pin level
  logic [5:0] sync_q;

  dbg_sync2 #(.W(6)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({reset_pin_n, pad_in}),
    .sync_out (sync_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  pin_cfg_t   cfg_ff, nxt_cfg;
  logic       standby_drive_enable_ff, nxt_standby_drive_enable;
  bus_state_t st_ff, nxt_st;
  logic [7:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;

  function automatic logic [31:0] rd_word(input logic [7:0] a, input pin_cfg_t c,
                                          input logic d, input logic [5:0] s,
                                          input logic h);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == OFS_FUNC) r[4:0] = c.func;
    else if (a == OFS_IE) r[4:0] = c.ie;
    else if (a == OFS_OE) r[4:0] = c.oe;
    else if (a == OFS_PUP) r[4:0] = c.pup;
    else if (a == OFS_PDN) r[4:0] = c.pdn;
    else if (a == OFS_GPOUT) r[4:0] = c.gpout;
    else if (a == OFS_GPIN) r[4:0] = s[4:0] & c.ie;
    else if (a == OFS_STATUS) r[2:0] = {h, s[5], c.func[BIT_CLK] & c.func[BIT_DATA]};
    else if (a == OFS_STBY) r[0] = d;
    return r;
  endfunction : rd_word

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_standby_drive_enable  = standby_drive_enable_ff;
    nxt_st    = ST_IDLE;
    nxt_addr  = addr_ff;
    nxt_rdata = rdata_ff;
    if (st_ff == ST_WRITE) begin
      if (addr_ff == OFS_FUNC) nxt_cfg.func = hwdata[4:0];
      else if (addr_ff == OFS_IE) nxt_cfg.ie = hwdata[4:0];
      else if (addr_ff == OFS_OE) nxt_cfg.oe = hwdata[4:0];
      else if (addr_ff == OFS_PUP) nxt_cfg.pup = hwdata[4:0];
      else if (addr_ff == OFS_PDN) nxt_cfg.pdn = hwdata[4:0];
      else if (addr_ff == OFS_GPOUT) nxt_cfg.gpout = hwdata[4:0];
      else if (addr_ff == OFS_STBY) nxt_standby_drive_enable = hwdata[0];
    end
    if (hsel && hready && htrans[1]) begin
      nxt_addr = {haddr[7:2], 2'b00};
      if (hwrite) begin
        nxt_st = ST_WRITE;
      end else begin
        nxt_st    = ST_READ;
        nxt_rdata = rd_word({haddr[7:2], 2'b00}, cfg_ff, standby_drive_enable_ff, sync_q, core_halted);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff   <= '{func: RST_FUNC, ie: RST_IE, oe: RST_OE,
                    pup: RST_PUP, pdn: RST_PDN, gpout: RST_GPOUT};
      standby_drive_enable_ff  <= RST_STANDBY_DRIVE_ENABLE;
      st_ff    <= ST_IDLE;
      addr_ff  <= 8'h00;
      rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ff   <= nxt_cfg;
      standby_drive_enable_ff  <= nxt_standby_drive_enable;
      st_ff    <= nxt_st;
      addr_ff  <= nxt_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb begin
    hrdata    = rdata_ff;
    hreadyout = 1'b1;
    hresp     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad mux and debug side signals
  pad_drv_t nxt_pad;
  logic     nxt_data_in, nxt_clk_in, nxt_wdt, nxt_dbgen;
  logic     keep_drive;

  always_comb begin
    keep_drive  = 1'b0;
    nxt_pad.pup = cfg_ff.pup;
    nxt_pad.pdn = cfg_ff.pdn;
    nxt_pad.out = cfg_ff.gpout;
    for (int i = 0; i < NPINS; i++) begin
      nxt_pad.oe[i] = cfg_ff.oe[i] & ~(stop_mode & ~standby_drive_enable_ff);
    end
    if (cfg_ff.func[BIT_DATA]) begin
      nxt_pad.out[BIT_DATA] = dbg_data_out;
      keep_drive = cfg_ff.oe[BIT_DATA] & dbg_data_oe;
      nxt_pad.oe[BIT_DATA] = keep_drive;
    end
    if (cfg_ff.func[BIT_CLK]) begin
      nxt_pad.oe[BIT_CLK] = 1'b0;
    end
    if (cfg_ff.func[BIT_VIEWER]) begin
      nxt_pad.out[BIT_VIEWER] = viewer_trace_output;
      nxt_pad.oe[BIT_VIEWER]  = cfg_ff.oe[BIT_VIEWER];
    end
    if (cfg_ff.func[BIT_TCLK]) begin
      nxt_pad.out[BIT_TCLK] = trace_clock_output;
    end
    if (cfg_ff.func[BIT_TDATA]) begin
      nxt_pad.out[BIT_TDATA] = trace_data_output;
    end
    nxt_dbgen   = sync_q[5] & cfg_ff.func[BIT_DATA] & cfg_ff.func[BIT_CLK];
    nxt_data_in = nxt_dbgen & cfg_ff.ie[BIT_DATA] & sync_q[BIT_DATA];
    nxt_clk_in  = nxt_dbgen & cfg_ff.ie[BIT_CLK] & sync_q[BIT_CLK];
    nxt_wdt     = core_halted;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_drv     <= '{out: RST_GPOUT, oe: RST_OE, pup: RST_PUP, pdn: RST_PDN};
      dbg_data_in <= 1'b0;
      dbg_clk_in  <= 1'b0;
      wdt_stop    <= 1'b0;
      dbg_enable  <= 1'b0;
    end else begin
      pad_drv     <= nxt_pad;
      dbg_data_in <= nxt_data_in;
      dbg_clk_in  <= nxt_clk_in;
      wdt_stop    <= nxt_wdt;
      dbg_enable  <= nxt_dbgen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_func_default: assert property (@(posedge hclk)
    $rose(hresetn) |-> cfg_ff.func == RST_FUNC && cfg_ff.pdn == RST_PDN)
    else $error("debug pins not debug after reset");

  a_viewer_stop_drive: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff.func[BIT_VIEWER] && cfg_ff.oe[BIT_VIEWER] && stop_mode |=> pad_drv.oe[BIT_VIEWER])
    else $error("viewer driver dropped in stop");

  a_clk_input_only: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff.func[BIT_CLK] |=> !pad_drv.oe[BIT_CLK])
    else $error("clock pin driven");

  a_halt_wdt_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    core_halted |=> wdt_stop)
    else $error("watchdog not stopped in halt");

  a_reset_pin_block: assert property (@(posedge hclk) disable iff (!hresetn)
    !sync_q[5] |=> !dbg_enable && !dbg_clk_in)
    else $error("debug active during reset pin");

  a_gp_path_out: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg_ff.func[BIT_TDATA] |=> pad_drv.out[BIT_TDATA] == $past(cfg_ff.gpout[BIT_TDATA]))
    else $error("port path not selected");

  a_trace_out_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_ff.func[BIT_TCLK] |=> pad_drv.out[BIT_TCLK] == $past(trace_clock_output))
    else $error("trace clock not routed");

  a_reset_pad_oe: assert property (@(posedge hclk)
    $rose(hresetn) |-> pad_drv.oe == RST_OE && pad_drv.pup == RST_PUP)
    else $error("pad reset settings wrong");

endmodule : dbg_pin_mux
`default_nettype wire

// ===== rtl/dbg_pin_pkg.sv
/*
  Shared constants and carriers for the debug pin function select block.
  Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
*/
package dbg_pin_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_FUNC   = 8'h00;
  localparam logic [7:0] OFS_IE     = 8'h04;
  localparam logic [7:0] OFS_OE     = 8'h08;
  localparam logic [7:0] OFS_PUP    = 8'h0c;
  localparam logic [7:0] OFS_PDN    = 8'h10;
  localparam logic [7:0] OFS_GPOUT  = 8'h14;
  localparam logic [7:0] OFS_GPIN   = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_STBY   = 8'h20;

  // Bit positions of the five shared pins in every per-pin register
  localparam int BIT_DATA   = 0;
  localparam int BIT_CLK    = 1;
  localparam int BIT_TCLK   = 2;
  localparam int BIT_TDATA  = 3;
  localparam int BIT_VIEWER = 4;
  localparam int NPINS      = 5;

  // Values after reset: data, clock, trace clock, trace data, viewer
  localparam logic [4:0] RST_FUNC  = 5'h13;
  localparam logic [4:0] RST_IE    = 5'h03;
  localparam logic [4:0] RST_OE    = 5'h11;
  localparam logic [4:0] RST_PUP   = 5'h01;
  localparam logic [4:0] RST_PDN   = 5'h02;
  localparam logic [4:0] RST_GPOUT = 5'h00;
  localparam logic       RST_STANDBY_DRIVE_ENABLE  = 1'b0;

  // Per-pin settings travel together
  typedef struct packed {
    logic [4:0] func;
    logic [4:0] ie;
    logic [4:0] oe;
    logic [4:0] pup;
    logic [4:0] pdn;
    logic [4:0] gpout;
  } pin_cfg_t;

  // Pad drive for all shared pins
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
    logic [4:0] pup;
    logic [4:0] pdn;
  } pad_drv_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } bus_state_t;

endpackage : dbg_pin_pkg

// ===== rtl/dbg_sync2.sv
/*
  Two-flop synchroniser for a vector of asynchronous inputs.
  Assumes the inputs are static for at least two destination clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dbg_sync2 #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= nxt_meta;
      sync_out <= nxt_sync;
    end
  end

endmodule : dbg_sync2
`default_nettype wire

// ===== tb/dbg_probe.sv
/*
  Debug probe model: runs serial clock frames on the data and clock pins.
  Assumes the bench resolves the data wire from all drivers and the pulls.
*/
`timescale 1ns/1ps
`default_nettype none
module dbg_probe (
  input  wire logic go,
  input  wire logic reset_pin_n,
  output var  logic clk_pad,
  output var  logic dio_drv,
  output var  logic dio_oe
);
  initial begin
    clk_pad = 1'b0;
    dio_drv = 1'b0;
    dio_oe  = 1'b0;
  end
  // Clock stands still between frames
  always @(posedge go) begin
    if (reset_pin_n) begin
      repeat (8) begin
        dio_oe  = 1'b1;
        dio_drv = ~dio_drv;
        #62.5 clk_pad = 1'b1;
        #62.5 clk_pad = 1'b0;
      end
      dio_oe = 1'b0;
    end
  end
endmodule : dbg_probe
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Self-checking bench for the debug pin function select block.
  Assumes zero-wait AHB-Lite and pads resolved from pad_drv and the pulls.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
  import dbg_pin_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic en;} row_t;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  pad_in;
  pad_drv_t    pad_drv;
  logic        d_out, d_oe, vw, tck, tdt, d_in, c_in, stp, hlt, rpin_n, wdt, den, go, pclk, pdio, poe, cq;
  int          err_count, total_checks, cyc, edges, e0;
  logic [7:0]  ra [7] = '{OFS_FUNC, OFS_IE, OFS_OE, OFS_PUP, OFS_PDN, OFS_GPOUT, OFS_STBY};
  logic [4:0]  rv [7] = '{RST_FUNC, RST_IE, RST_OE, RST_PUP, RST_PDN, RST_GPOUT, {4'h0, RST_STANDBY_DRIVE_ENABLE}};
  row_t        rows [7] = '{'{OFS_FUNC, 32'h3, 32'h3, 1'b1}, '{OFS_FUNC, 32'hf, 32'hf, 1'b1},
    '{OFS_FUNC, 32'h0, 32'h0, 1'b0}, '{OFS_IE, 32'hffffffff, 32'h1f, 1'b0},
    '{OFS_GPOUT, 32'hffffffea, 32'ha, 1'b0}, '{8'h24, 32'hffffffff, 32'h0, 1'b0},
    '{OFS_FUNC, 32'h13, 32'h13, 1'b1}};

  assign hready = hreadyout;
  assign pad_in[0] = pad_drv.oe[0] ? pad_drv.out[0] : (poe ? pdio : pad_drv.pup[0]);
  assign pad_in[1] = pclk;
  assign pad_in[4:2] = (pad_drv.oe[4:2] & pad_drv.out[4:2]) | (~pad_drv.oe[4:2] & pad_drv.pup[4:2]);

  dbg_pin_mux u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_drv(pad_drv), .dbg_data_out(d_out),
    .dbg_data_oe(d_oe), .viewer_trace_output(vw), .trace_clock_output(tck), .trace_data_output(tdt),
    .dbg_data_in(d_in), .dbg_clk_in(c_in), .stop_mode(stp), .core_halted(hlt), .reset_pin_n(rpin_n),
    .wdt_stop(wdt), .dbg_enable(den));
  dbg_probe u_probe (.go(go), .reset_pin_n(rpin_n), .clk_pad(pclk), .dio_drv(pdio), .dio_oe(poe));

  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cq <= c_in;
    if (c_in && !cq) edges++;
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // Single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd = hrdata;
  endtask : xfer

  ////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, d_out, d_oe, vw, tck, tdt, stp, hlt, go} = '0;
    hsize = 3'b010;
    rpin_n = 1'b1;
    hresetn = 1'b0;
    tick(20);
    `CHK(pad_drv, {5'h00, RST_OE, RST_PUP, RST_PDN})
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ra[i], '0);
      `CHK(rd, {27'h0, rv[i]})
    end
    `CHK({hreadyout, hresp}, 2'b10)
    `CHK(den, 1'b1)
    $display("reset values done");
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].w);
      xfer(1'b0, rows[i].a, '0);
      `CHK(rd, rows[i].r)
      tick(4);
      `CHK(den, rows[i].en)
    end
    $display("register rows done");
    d_out <= 1'b1;
    d_oe <= 1'b1;
    vw <= 1'b1;
    tck <= 1'b1;
    xfer(1'b1, OFS_OE, 32'h1f);
    xfer(1'b1, OFS_FUNC, 32'h1f);
    tick(3);
    `CHK(pad_drv.out & 5'h1d, 5'h15)
    `CHK(pad_drv.oe, 5'h1d)
    tick(2);
    `CHK(d_in, 1'b1)
    xfer(1'b1, OFS_FUNC, 32'h0);
    tick(3);
    `CHK(pad_drv.out, 5'h0a)
    `CHK(pad_drv.oe, 5'h1f)
    `CHK(d_in, 1'b0)
    xfer(1'b0, OFS_GPIN, '0);
    `CHK(rd, 32'h8)
    $display("pin select done");
    xfer(1'b1, OFS_FUNC, 32'h13);
    stp <= 1'b1;
    tick(3);
    `CHK(pad_drv.oe, 5'h11)
    xfer(1'b1, OFS_STBY, 32'h1);
    tick(3);
    `CHK(pad_drv.oe, 5'h1d)
    d_oe <= 1'b0;
    tick(3);
    `CHK(pad_drv.oe, 5'h1c)
    stp <= 1'b0;
    $display("stop drive done");
    hlt <= 1'b1;
    tick(3);
    `CHK(wdt, 1'b1)
    xfer(1'b0, OFS_STATUS, '0);
    `CHK(rd, 32'h7)
    hlt <= 1'b0;
    tick(3);
    `CHK(wdt, 1'b0)
    $display("halt done");
    for (int k = 0; k < 3; k++) begin
      rpin_n <= (k != 1);
      xfer(1'b1, OFS_FUNC, (k == 2) ? 32'h0 : 32'h13);
      tick(6);
      if (k == 1) `CHK(den, 1'b0)
      e0 = edges;
      go <= 1'b1;
      tick(110);
      go <= 1'b0;
      `CHK(edges - e0, (k == 0) ? 8 : 0)
      `CHK(d_in, k == 0)
    end
    $display("probe frames done");
    hresetn <= 1'b0;
    tick(2);
    `CHK(pad_drv.oe, RST_OE)
    hresetn <= 1'b1;
    xfer(1'b0, OFS_FUNC, '0);
    `CHK(rd, {27'h0, RST_FUNC})
    $display("second reset done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
